//--- hw/dcmr_params.svh
// Timing constants for the power-down and mode-register command pacer
`ifndef DCMR_PARAMS_SVH
`define DCMR_PARAMS_SVH

// ----------------------------------------
// Clock
// ----------------------------------------
`define DCMR_CLK_PS 50000
`define DCMR_BOOT_TCK_MAX_PS 100000
`define DCMR_SYNC_STAGES 2

// ----------------------------------------
// CKE windows, ps and clock counts
// ----------------------------------------
`define DCMR_TCKE_PS 7500
`define DCMR_TCKE_NCK 4
`define DCMR_CMDCKE_PS 1750
`define DCMR_CMDCKE_NCK 3
`define DCMR_CKELCK_PS 5000
`define DCMR_CKELCK_NCK 5
`define DCMR_CSCKE_PS 1750
`define DCMR_CKELCS_PS 5000
`define DCMR_CKELCS_NCK 5
`define DCMR_CKCKEH_PS 1750
`define DCMR_CKCKEH_NCK 3
`define DCMR_CSCKEH_PS 1750
`define DCMR_CKEHCS_PS 7500
`define DCMR_CKEHCS_NCK 5
`define DCMR_XP_PS 7500
`define DCMR_XP_NCK 5
`define DCMR_MRWCKEL_PS 14000
`define DCMR_MRWCKEL_NCK 10
`define DCMR_ZQCKE_PS 1750
`define DCMR_ZQCKE_NCK 3

// ----------------------------------------
// Mode-register spacing
// ----------------------------------------
`define DCMR_MRW_PS 10000
`define DCMR_MRW_NCK 10
`define DCMR_MRD_PS 14000
`define DCMR_MRD_NCK 10
`define DCMR_MRR_NCK 8
`define DCMR_RCD_PS 18000
`define DCMR_RCD_NCK 4
`define DCMR_MRRI_NCK 3
`define DCMR_SDO_PS 20000
`define DCMR_SDO_NCK 12

`endif

//--- hw/dcmr_pkg.sv
// Types shared by the power-down and mode-register command pacer
package dcmr_pkg;

  // ----------------------------------------
  // Command kinds
  // ----------------------------------------
  typedef enum logic [2:0] {
    DCMR_CMD_OTHER,
    DCMR_CMD_MRW,
    DCMR_CMD_MRR,
    DCMR_CMD_ZQ_START
  } dcmr_cmd_e;

  // Request from the user side
  typedef struct packed {
    dcmr_cmd_e cmd;
    logic [5:0] addr;
    logic [7:0] op;
    logic dqs_on;
  } dcmr_req_s;

  // Command presented toward the memory
  typedef struct packed {
    logic valid;
    dcmr_cmd_e cmd;
    logic [5:0] addr;
    logic [7:0] op;
  } dcmr_issue_s;

  // Power state sequencer
  typedef enum logic [2:0] {
    DCMR_ST_ACTIVE,
    DCMR_ST_PDE_CS,
    DCMR_ST_PD_HOLD,
    DCMR_ST_PD_STOP,
    DCMR_ST_PDX_CLK
  } dcmr_state_e;

endpackage : dcmr_pkg

//--- hw/dcmr_ctrl.sv
// Host-side pacer for CKE power-down and mode-register commands
`timescale 1ns/1ns
`default_nettype none
`include "dcmr_params.svh"

module dcmr_ctrl
  import dcmr_pkg::*;
#(
  parameter int CLK_PS = `DCMR_CLK_PS,
  parameter int TW = 5
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic req_valid_i,
  input wire dcmr_req_s req_i,
  input wire logic pd_req_i,
  input wire logic dqs_i,
  output logic req_ready_o,
  output logic req_ack_o,
  output dcmr_issue_s issue_o,
  output logic cke_o,
  output logic cs_o,
  output logic ck_en_o,
  output logic pd_o,
  output logic sdo_err_o
);

  // ----------------------------------------
  // Cycle counts
  // ----------------------------------------

  // Larger of rounded-up ps time and clock count, never below one
  function automatic logic [TW-1:0] cyc(input int ps, input int nck);
    int c;
    c = (ps + CLK_PS - 1) / CLK_PS;
    if (nck > c) begin
      c = nck;
    end
    if (c < 1) begin
      c = 1;
    end
    return c[TW-1:0];
  endfunction : cyc

  // Larger of two counts
  function automatic logic [TW-1:0] mx(input logic [TW-1:0] a, input logic [TW-1:0] b);
    return (a > b) ? a : b;
  endfunction : mx

  // CKE minimum level width
  localparam logic [TW-1:0] C_CKE = cyc(`DCMR_TCKE_PS, `DCMR_TCKE_NCK);
  // Last command to CKE low
  localparam logic [TW-1:0] C_CMDCKE = cyc(`DCMR_CMDCKE_PS, `DCMR_CMDCKE_NCK);
  // Clock and CS valid after CKE low, plain case
  localparam logic [TW-1:0] C_CKEL = mx(cyc(`DCMR_CKELCK_PS, `DCMR_CKELCK_NCK),
                                        cyc(`DCMR_CKELCS_PS, `DCMR_CKELCS_NCK));
  // Same after a mode write
  localparam logic [TW-1:0] C_MRWL = mx(C_CKEL, cyc(`DCMR_MRWCKEL_PS, `DCMR_MRWCKEL_NCK));
  // Same after a calibration start
  localparam logic [TW-1:0] C_ZQL = mx(C_CKEL, cyc(`DCMR_ZQCKE_PS, `DCMR_ZQCKE_NCK));
  // CS setup before CKE low, whole cycles
  localparam logic [TW-1:0] C_CSCKE = cyc(`DCMR_CSCKE_PS, 1);
  // Clock and CS running before CKE high
  localparam logic [TW-1:0] C_CKCKEH = mx(cyc(`DCMR_CKCKEH_PS, `DCMR_CKCKEH_NCK),
                                          cyc(`DCMR_CSCKEH_PS, 1));
  // CS valid after CKE high
  localparam logic [TW-1:0] C_CKEHCS = cyc(`DCMR_CKEHCS_PS, `DCMR_CKEHCS_NCK);
  // Exit to first command
  localparam logic [TW-1:0] C_XP = cyc(`DCMR_XP_PS, `DCMR_XP_NCK);
  // Exit to first mode read: tXP then tRCD plus three clocks
  localparam logic [TW-1:0] C_MRRI = C_XP + cyc(`DCMR_RCD_PS, `DCMR_RCD_NCK)
                                     + cyc(0, `DCMR_MRRI_NCK);
  // Mode write spacing
  localparam logic [TW-1:0] C_MRW = cyc(`DCMR_MRW_PS, `DCMR_MRW_NCK);
  // Mode write to dependent command
  localparam logic [TW-1:0] C_MRD = cyc(`DCMR_MRD_PS, `DCMR_MRD_NCK);
  // Mode read spacing
  localparam logic [TW-1:0] C_MRR = cyc(0, `DCMR_MRR_NCK);
  // Strobe window, widened by the input synchroniser
  localparam logic [TW-1:0] C_SDO = cyc(`DCMR_SDO_PS, `DCMR_SDO_NCK)
                                    + cyc(0, `DCMR_SYNC_STAGES);
  // Boot clock must not be slower than the limit
  localparam bit BOOT_OK = (CLK_PS <= `DCMR_BOOT_TCK_MAX_PS);

  // ----------------------------------------
  // Timer indices
  // ----------------------------------------
  localparam int T_CKE = 0;
  localparam int T_CMDCKE = 1;
  localparam int T_CKEL = 2;
  localparam int T_CKCKEH = 3;
  localparam int T_CKEHCS = 4;
  localparam int T_XP = 5;
  localparam int T_MRW = 6;
  localparam int T_MRD = 7;
  localparam int T_MRR = 8;
  localparam int T_MRRI = 9;
  localparam int T_SDO = 10;
  localparam int T_CSCKE = 11;
  localparam int NT = 12;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  dcmr_state_e state_q; // Power sequencer state
  logic [TW-1:0] tmr_q [NT]; // Down-counters
  logic [NT-1:0] ld; // Per-timer load strobe
  logic [TW-1:0] ldv [NT]; // Per-timer load value
  logic [NT-1:0] zero; // Timer has expired
  dcmr_cmd_e last_cmd_q; // Last command before power-down
  logic sync1_q; // Strobe synchroniser, first stage
  logic dqs_q; // Strobe synchroniser, second stage
  logic watch_q; // Waiting for strobe after mode write
  logic cmd_ok; // Presented command meets its spacing
  logic take; // Command issued this cycle
  logic pd_go; // Power-down entry starts this cycle
  logic exit_go; // CKE rises this cycle
  logic sdo_ld; // Start of strobe watch

  // ----------------------------------------
  // Delay timers
  // ----------------------------------------

  // One down-counter per delay; load wins over counting
  genvar gi;
  generate
    for (gi = 0; gi < NT; gi++) begin : g_tmr
      always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
          tmr_q[gi] <= '0;
        end else if (ld[gi]) begin
          tmr_q[gi] <= ldv[gi];
        end else if (tmr_q[gi] != '0) begin
          tmr_q[gi] <= tmr_q[gi] - 1'b1;
        end
      end
      assign zero[gi] = (tmr_q[gi] == '0);
    end
  endgenerate

  // ----------------------------------------
  // Command admission
  // ----------------------------------------

  // Spacing check for the presented command
  always_comb begin
    cmd_ok = zero[T_XP] && zero[T_CKEHCS];
    case (req_i.cmd)
      DCMR_CMD_MRW: begin
        cmd_ok = cmd_ok && zero[T_MRW];
      end
      DCMR_CMD_MRR: begin
        cmd_ok = cmd_ok && zero[T_MRD] && zero[T_MRR] && zero[T_MRRI];
      end
      default: begin
        cmd_ok = cmd_ok && zero[T_MRD];
      end
    endcase
  end

  // Request is held by the user until acknowledged
  assign take = req_valid_i && req_ready_o && cmd_ok && (state_q == DCMR_ST_ACTIVE);

  // Power-down may start only once every entry delay has run out
  assign pd_go = (state_q == DCMR_ST_ACTIVE) && pd_req_i && !take
                 && zero[T_CMDCKE] && zero[T_CKE] && zero[T_CKEHCS];
  assign exit_go = (state_q == DCMR_ST_PDX_CLK) && zero[T_CKCKEH];
  assign sdo_ld = take && (req_i.cmd == DCMR_CMD_MRW) && req_i.dqs_on;

  // ----------------------------------------
  // Timer loads
  // ----------------------------------------

  // Which delays start on which event
  always_comb begin
    ld = '0;
    ld[T_CMDCKE] = take;
    ld[T_MRW] = take && (req_i.cmd == DCMR_CMD_MRW);
    ld[T_MRD] = take && (req_i.cmd == DCMR_CMD_MRW);
    ld[T_MRR] = take && (req_i.cmd == DCMR_CMD_MRR);
    ld[T_SDO] = sdo_ld;
    ld[T_CSCKE] = pd_go;
    ld[T_CKE] = (state_q == DCMR_ST_PDE_CS && zero[T_CSCKE]) || exit_go;
    ld[T_CKEL] = (state_q == DCMR_ST_PDE_CS && zero[T_CSCKE]);
    ld[T_CKCKEH] = (state_q == DCMR_ST_PD_STOP) && !pd_req_i;
    ld[T_CKEHCS] = exit_go;
    ld[T_XP] = exit_go;
    ld[T_MRRI] = exit_go;
  end

  // Load values; the hold after CKE low depends on the last command
  always_comb begin
    ldv[T_CKE] = C_CKE;
    ldv[T_CMDCKE] = C_CMDCKE;
    ldv[T_CKCKEH] = C_CKCKEH;
    ldv[T_CKEHCS] = C_CKEHCS;
    ldv[T_XP] = C_XP;
    ldv[T_MRW] = C_MRW;
    ldv[T_MRD] = C_MRD;
    ldv[T_MRR] = C_MRR;
    ldv[T_MRRI] = C_MRRI;
    ldv[T_SDO] = C_SDO;
    ldv[T_CSCKE] = C_CSCKE;
    if (last_cmd_q == DCMR_CMD_MRW) begin
      ldv[T_CKEL] = C_MRWL;
    end else if (last_cmd_q == DCMR_CMD_ZQ_START) begin
      ldv[T_CKEL] = C_ZQL;
    end else begin
      ldv[T_CKEL] = C_CKEL;
    end
  end

  // ----------------------------------------
  // Power sequencer
  // ----------------------------------------

  // Entry: CS settle, CKE low, hold clock, stop clock
  // Exit: restart clock, wait, raise CKE
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      state_q <= DCMR_ST_ACTIVE;
    end else begin
      case (state_q)
        DCMR_ST_ACTIVE: begin
          if (pd_go) begin
            state_q <= DCMR_ST_PDE_CS;
          end
        end
        DCMR_ST_PDE_CS: begin
          // CS sits deselected at least two full cycles before CKE drops
          if (zero[T_CSCKE]) begin
            state_q <= DCMR_ST_PD_HOLD;
          end
        end
        DCMR_ST_PD_HOLD: begin
          // Clock and CS stay valid, and CKE low holds tCKE
          if (zero[T_CKEL] && zero[T_CKE]) begin
            state_q <= DCMR_ST_PD_STOP;
          end
        end
        DCMR_ST_PD_STOP: begin
          if (!pd_req_i) begin
            state_q <= DCMR_ST_PDX_CLK;
          end
        end
        DCMR_ST_PDX_CLK: begin
          if (exit_go) begin
            state_q <= DCMR_ST_ACTIVE;
          end
        end
        default: begin
          state_q <= DCMR_ST_ACTIVE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Pins toward the memory
  // ----------------------------------------

  // CKE drops on leaving the CS settle state, rises on exit
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      cke_o <= 1'b1;
    end else if (state_q == DCMR_ST_PDE_CS && zero[T_CSCKE]) begin
      cke_o <= 1'b0;
    end else if (exit_go) begin
      cke_o <= 1'b1;
    end
  end

  // Clock gate: off only once the post-entry hold is over
  // Gating keeps the clock off for good when the reference is slower than the boot limit
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      ck_en_o <= BOOT_OK;
    end else if (state_q == DCMR_ST_PD_HOLD && zero[T_CKEL] && zero[T_CKE]) begin
      ck_en_o <= 1'b0;
    end else if (state_q == DCMR_ST_PD_STOP && !pd_req_i) begin
      ck_en_o <= BOOT_OK;
    end
  end

  // CS high only in the issue cycle; low is a valid deselect level
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      cs_o <= 1'b0;
    end else begin
      cs_o <= take;
    end
  end

  // Registered command word, valid for one cycle
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      issue_o <= '0;
    end else begin
      issue_o.valid <= take;
      issue_o.cmd <= take ? req_i.cmd : DCMR_CMD_OTHER;
      issue_o.addr <= take ? req_i.addr : 6'h00;
      issue_o.op <= take ? req_i.op : 8'h00;
    end
  end

  // ----------------------------------------
  // User handshake
  // ----------------------------------------

  // Ready drops while power-down is wanted or under way
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      req_ready_o <= 1'b0;
    end else begin
      req_ready_o <= (state_q == DCMR_ST_ACTIVE) && !pd_go && !pd_req_i && !exit_go;
    end
  end

  // Acknowledge pulse in the issue cycle
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      req_ack_o <= 1'b0;
    end else begin
      req_ack_o <= take;
    end
  end

  // Power-down status: high from the cycle after CKE low until CKE high
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      pd_o <= 1'b0;
    end else begin
      pd_o <= (state_q == DCMR_ST_PD_HOLD) || (state_q == DCMR_ST_PD_STOP)
              || (state_q == DCMR_ST_PDX_CLK && !exit_go);
    end
  end

  // Remember the last command to size the post-entry hold
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      last_cmd_q <= DCMR_CMD_OTHER;
    end else if (take) begin
      last_cmd_q <= req_i.cmd;
    end
  end

  // ----------------------------------------
  // Strobe watch
  // ----------------------------------------

  // Two-stage synchroniser on the strobe pin
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      sync1_q <= 1'b0;
      dqs_q <= 1'b0;
    end else begin
      sync1_q <= dqs_i;
      dqs_q <= sync1_q;
    end
  end

  // Sticky error if the device never drives the strobe in time
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      watch_q <= 1'b0;
      sdo_err_o <= 1'b0;
    end else if (sdo_ld) begin
      watch_q <= 1'b1;
    end else if (watch_q && dqs_q) begin
      watch_q <= 1'b0;
    end else if (watch_q && zero[T_SDO]) begin
      watch_q <= 1'b0;
      sdo_err_o <= 1'b1;
    end
  end

endmodule : dcmr_ctrl

`default_nettype wire

//--- dv/dcmr_ctrl_properties.sv
// Port-level timing checks for the CKE and mode-register pacer
`timescale 1ns/1ns
`default_nettype none
module dcmr_ctrl_properties
  import dcmr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire dcmr_issue_s issue_o,
  input wire logic cke_o,
  input wire logic cs_o,
  input wire logic ck_en_o
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  logic mrw_q; // Last command was a mode write
  logic is_mrw; // Mode write on the bus
  logic is_mrr; // Mode read on the bus
  assign is_mrw = issue_o.valid && (issue_o.cmd == DCMR_CMD_MRW);
  assign is_mrr = issue_o.valid && (issue_o.cmd == DCMR_CMD_MRR);
  // Kind of the last command, for the longer hold
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      mrw_q <= 1'b0;
    end else if (issue_o.valid) begin
      mrw_q <= is_mrw;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);
  cke_hold_a: assert property ($changed(cke_o) |=> $stable(cke_o)[*3])
    else $error("cke level held too briefly");
  cmd_to_ckel_a: assert property ($fell(cke_o) |-> !$past(cs_o, 1) && !$past(cs_o, 2))
    else $error("cke fell too soon after a command");
  ckel_valid_a: assert property ($fell(cke_o) |-> (ck_en_o && !cs_o)[*5])
    else $error("clock or select lost after cke fell");
  mrw_ckel_a: assert property ($fell(cke_o) && mrw_q |->
    (ck_en_o && !cs_o)[*8] ##1 (ck_en_o && !cs_o)[*2])
    else $error("short hold after mode write");
  ck_before_ckeh_a: assert property ($rose(cke_o) |->
    $past(ck_en_o, 1) && $past(ck_en_o, 2) && $past(ck_en_o, 3))
    else $error("clock not running before cke rose");
  cs_after_ckeh_a: assert property ($rose(cke_o) |-> (!cs_o)[*5])
    else $error("select asserted too soon after cke rose");
  exit_cmd_a: assert property ($rose(cke_o) |-> (!issue_o.valid)[*5])
    else $error("command too soon after exit");
  mrw_space_a: assert property (is_mrw |=> (!is_mrw)[*8] ##1 !is_mrw)
    else $error("mode writes too close");
  mrd_wait_a: assert property (is_mrw |=> (!issue_o.valid)[*8] ##1 !issue_o.valid)
    else $error("command too soon after mode write");
  mrr_space_a: assert property (is_mrr |=> (!is_mrr)[*7])
    else $error("mode reads too close");
  mrr_exit_a: assert property ($rose(cke_o) |-> (!is_mrr)[*8] ##1 (!is_mrr)[*3])
    else $error("mode read too soon after exit");
endmodule : dcmr_ctrl_properties

bind dcmr_ctrl dcmr_ctrl_properties dcmr_ctrl_properties_inst (
  .ref_clk_i(ref_clk_i),
  .rstn_i(rstn_i),
  .issue_o(issue_o),
  .cke_o(cke_o),
  .cs_o(cs_o),
  .ck_en_o(ck_en_o)
);
`default_nettype wire

//--- dv/dcmr_dev_model.sv
// Memory-side model: answers mode writes with a strobe
`timescale 1ns/1ns
`default_nettype none
module dcmr_dev_model
  import dcmr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic ck_en_i,
  input wire logic cke_i,
  input wire logic cs_i,
  input wire dcmr_issue_s issue_i,
  input wire logic slow_i,
  output logic dqs_o,
  output var int early_o
);
  int wait_q = 0; // Cycles left until the strobe
  int xp_q = 0; // Exit lockout, commands ignored
  logic cke_q = 1'b1; // CKE seen last CK edge
  initial begin
    dqs_o = 1'b0;
    early_o = 0;
  end
  // Runs only on live CK; strobe idles low through the VSS termination
  always @(posedge ref_clk_i) begin
    if (ck_en_i) begin
      cke_q <= cke_i;
      dqs_o <= (wait_q == 1) || (wait_q == 2);
      if (wait_q > 0) begin
        wait_q <= wait_q - 1;
      end
      if (cke_i && !cke_q) begin
        xp_q <= 4;
      end else if (xp_q > 0) begin
        xp_q <= xp_q - 1;
      end
      if (cs_i && issue_i.valid) begin
        if (xp_q > 0) begin
          early_o <= early_o + 1;
        end else if (issue_i.cmd == DCMR_CMD_MRW) begin
          wait_q <= slow_i ? 40 : 4;
        end
      end
    end
  end
endmodule : dcmr_dev_model
`default_nettype wire

//--- dv/dcmr_ctrl_tb.sv
// Self-checking bench for the CKE and mode-register pacer
`timescale 1ns/1ns
`default_nettype none
module dcmr_ctrl_tb
  import dcmr_pkg::*;
;
  logic ref_clk_i;
  logic rstn_i;
  logic req_valid_i;
  dcmr_req_s req_i;
  logic pd_req_i;
  logic dqs_i;
  logic req_ready_o;
  logic req_ack_o;
  dcmr_issue_s issue_o;
  logic cke_o;
  logic cs_o;
  logic ck_en_o;
  logic pd_o;
  logic sdo_err_o;
  logic slow; // Model answers late
  int early; // Commands the model ignored
  int cyc = 0; // Rising edges so far
  int mismatches = 0;
  int checks = 0;

  dcmr_ctrl dcmr_ctrl_inst (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .pd_req_i(pd_req_i), .dqs_i(dqs_i),
    .req_ready_o(req_ready_o), .req_ack_o(req_ack_o), .issue_o(issue_o),
    .cke_o(cke_o), .cs_o(cs_o), .ck_en_o(ck_en_o), .pd_o(pd_o),
    .sdo_err_o(sdo_err_o)
  );
  dcmr_dev_model dcmr_dev_model_inst (
    .ref_clk_i(ref_clk_i), .ck_en_i(ck_en_o), .cke_i(cke_o), .cs_i(cs_o),
    .issue_i(issue_o), .slow_i(slow), .dqs_o(dqs_i), .early_o(early)
  );

  // ----------------------------------------
  // Clock and shared tasks
  // ----------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) cyc <= cyc + 1;

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk

  // Hold the request until acknowledged; the edge it was taken on is returned
  task automatic send(input dcmr_cmd_e c, input logic on, output int at);
    int n;
    @(negedge ref_clk_i);
    req_i = '{cmd: c, addr: 6'h05, op: 8'h3c, dqs_on: on};
    req_valid_i = 1'b1;
    for (n = 0; n < 60 && req_ack_o !== 1'b1; n++) @(negedge ref_clk_i);
    at = cyc;
    req_valid_i = 1'b0;
    chk("req_ack", 32'(req_ack_o), 32'h1);
    // Command word and select stand in the acknowledge cycle only
    chk("issue_valid", 32'(issue_o.valid), 32'h1);
    chk("issue_cmd", 32'(issue_o.cmd), 32'(c));
    chk("issue_addr", 32'(issue_o.addr), 32'h5);
    chk("issue_op", 32'(issue_o.op), 32'h3c);
    chk("cs_in_issue", 32'(cs_o), 32'h1);
  endtask : send

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_mode();
    int a;
    int b;
    send(DCMR_CMD_MRW, 1'b1, a);
    send(DCMR_CMD_MRW, 1'b1, b);
    chk("mrw_gap", 32'((b - a >= 10) && (b - a <= 11)), 32'h1);
    send(DCMR_CMD_OTHER, 1'b0, a);
    chk("mrd_gap", 32'((a - b >= 10) && (a - b <= 11)), 32'h1);
    send(DCMR_CMD_MRR, 1'b0, a);
    send(DCMR_CMD_MRR, 1'b0, b);
    chk("mrr_gap", 32'((b - a >= 8) && (b - a <= 9)), 32'h1);
    chk("strobe_seen", 32'(sdo_err_o), 32'h0);
  endtask : t_mode

  // Command, power-down, clock stop, exit, then a mode read
  task automatic t_pd(input dcmr_cmd_e c, input int hold);
    int a;
    int n;
    int f;
    send(c, 1'b0, a);
    pd_req_i = 1'b1;
    for (n = 0; n < 60 && cke_o !== 1'b0; n++) @(negedge ref_clk_i);
    f = cyc;
    chk("cmd_to_ckel", 32'(f - a >= 3), 32'h1);
    for (n = 0; n < 60 && ck_en_o !== 1'b0; n++) @(negedge ref_clk_i);
    chk("ckel_hold", 32'(cyc - f >= hold), 32'h1);
    chk("pd_level", 32'(pd_o), 32'h1);
    chk("ready_in_pd", 32'(req_ready_o), 32'h0);
    pd_req_i = 1'b0;
    for (n = 0; n < 60 && ck_en_o !== 1'b1; n++) @(negedge ref_clk_i);
    f = cyc;
    for (n = 0; n < 60 && cke_o !== 1'b1; n++) @(negedge ref_clk_i);
    // Three restart cycles, plus the edge on which CKE is registered high
    chk("ck_before_ckeh", 32'(cyc - f), 32'h4);
    f = cyc;
    send(DCMR_CMD_MRR, 1'b0, a);
    chk("exit_to_mrr", 32'(a - f >= 12), 32'h1);
    chk("early_cmds", 32'(early), 32'h0);
  endtask : t_pd

  // Strobe never comes in time; only a reset clears the flag
  task automatic t_late();
    int a;
    slow = 1'b1;
    send(DCMR_CMD_MRW, 1'b1, a);
    repeat (16) @(negedge ref_clk_i);
    chk("strobe_late", 32'(sdo_err_o), 32'h1);
    rstn_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    rstn_i = 1'b1;
    slow = 1'b0;
    // First edge after release: flag gone, ready back, CKE still high
    @(negedge ref_clk_i);
    chk("err_cleared", 32'(sdo_err_o), 32'h0);
    chk("ready_after_reset", 32'(req_ready_o), 32'h1);
    chk("cke_after_reset", 32'(cke_o), 32'h1);
  endtask : t_late

  initial begin
    rstn_i = 1'b0;
    req_valid_i = 1'b0;
    req_i = '0;
    pd_req_i = 1'b0;
    slow = 1'b0;
    repeat (12) @(negedge ref_clk_i);
    rstn_i = 1'b1;
    t_mode();
    t_pd(DCMR_CMD_MRW, 10);
    t_pd(DCMR_CMD_ZQ_START, 3);
    t_pd(DCMR_CMD_OTHER, 5);
    t_late();
    t_mode();
    close_out();
  end

  // Watchdog well past the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    mismatches++;
    close_out();
  end
endmodule : dcmr_ctrl_tb
`default_nettype wire
